// ==== qfp_fetch_pipeline.v ====
// Quad-phase fetch pipeline: phase generator, PC, fetch latch and small execute unit
// Function
// RL1 - Divide clock by four into ordered phases
// RL2 - Program counter advances every first phase
// RL3 - Fetched word captured in fourth phase
// RL4 - Latched instruction executes phases one to four
// RL5 - Operand read phase two, write phase four
// RL6 - Fetch overlaps execute, one per cycle
// RL7 - PC change flushes prefetched word as no-op
// RL8 - Byte-addressed memory, instructions on even addresses
// RL9 - PC steps by two, LSB reads zero
// RL10 - Absolute jumps load word address into PC
// RL11 - Relative offset counts words, scaled to bytes
// RL12 - Add working register to PC low byte
// RL13 - Return with literal pops, loads literal
// RL14 - Table transfers move one byte at pointer
// RL15 - Lone second word executes as no-op
// RL16 - Reset restarts phase one, empties pipeline
`timescale 1ns/100ps
`default_nettype none
`include "qfp_map.vh"

module qfp_fetch_pipeline
(
  // Clock and reset
  input  wire                        sys_clk_i,
  input  wire                        sys_rst_i,
  // Phase enables
  output wire                        q1_o,
  output wire                        q2_o,
  output wire                        q3_o,
  output wire                        q4_o,
  // Program memory port
  output wire [`QFP_PC_W-1:0]        pm_addr_o,
  output wire                        pm_rd_o,
  input  wire [`QFP_WORD_W-1:0]      pm_data_i,
  output wire                        pm_wr_o,
  output wire [`QFP_BYTE_W-1:0]      pm_wdata_o,
  // Data memory port
  output wire [`QFP_DM_AW-1:0]       dm_addr_o,
  output wire                        dm_rd_o,
  input  wire [`QFP_BYTE_W-1:0]      dm_rdata_i,
  output wire                        dm_wr_o,
  output wire [`QFP_BYTE_W-1:0]      dm_wdata_o,
  // Table access
  input  wire [`QFP_PC_W-1:0]        table_pointer_i,
  output wire [`QFP_BYTE_W-1:0]      table_data_latch_o,
  // Core status
  output wire [`QFP_PC_W-1:0]        pc_o,
  output wire [`QFP_BYTE_W-1:0]      working_register_o,
  output wire                        exec_valid_o
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  reg  [1:0]              phase_reg;               // Current phase
  reg  [`QFP_PC_W-1:0]    pc_reg;                  // Next fetch address
  reg  [`QFP_PC_W-1:0]    fetch_addr_reg;          // Address being fetched
  reg  [`QFP_PC_W-1:0]    pm_addr_reg;             // Program memory address
  reg  [`QFP_WORD_W-1:0]  instruction_latch_reg;   // Word being executed
  reg                     exec_valid_reg;          // Latch holds a live word
  reg                     copy_pend_reg;           // Latched word is a move destination
  reg  [`QFP_PC_W-1:0]    ret_addr_reg;            // Single-level return address
  reg  [`QFP_BYTE_W-1:0]  working_register_reg;    // Accumulator
  reg  [`QFP_BYTE_W-1:0]  table_data_latch_reg;    // Table byte
  reg  [`QFP_BYTE_W-1:0]  operand_reg;             // Operand read in Q2
  reg  [`QFP_BYTE_W-1:0]  result_reg;              // Write data formed in Q3
  reg  [`QFP_DM_AW-1:0]   dm_addr_reg;             // Data memory address

  // ----------------------------------------------------------------------
  // Phase decode
  // ----------------------------------------------------------------------
  wire ph1 = (phase_reg == `QFP_PH_Q1);
  wire ph2 = (phase_reg == `QFP_PH_Q2);
  wire ph3 = (phase_reg == `QFP_PH_Q3);
  wire ph4 = (phase_reg == `QFP_PH_Q4);

  // ----------------------------------------------------------------------
  // Instruction decode, gated by a live latch
  // ----------------------------------------------------------------------
  wire [`QFP_WORD_W-1:0] ins = instruction_latch_reg;
  wire [7:0]  lit     = ins[7:0];                  // Literal or file address
  wire        acc     = ~ins[8];                   // Access bank selected
  wire        dest_f  = ins[9];                    // Destination is file
  wire        dec_goto  = exec_valid_reg & (ins[15:8]  == `QFP_OP_GOTO);
  wire        dec_call  = exec_valid_reg & (ins[15:9]  == `QFP_OP_CALL);
  wire        dec_rjmp  = exec_valid_reg & (ins[15:11] == `QFP_OP_RJMP);
  wire        dec_fcopy = exec_valid_reg & (ins[15:12] == `QFP_OP_FCOPY);
  wire        dec_addw  = exec_valid_reg & (ins[15:10] == `QFP_OP_ADDW);
  wire        dec_stow  = exec_valid_reg & (ins[15:9]  == `QFP_OP_STOW);
  wire        dec_ldlit = exec_valid_reg & (ins[15:8]  == `QFP_OP_LDLIT);
  wire        dec_rtlit = exec_valid_reg & (ins[15:8]  == `QFP_OP_RTLIT);
  wire        dec_tabrd = exec_valid_reg & (ins == `QFP_OP_TABRD);
  wire        dec_tabwr = exec_valid_reg & (ins == `QFP_OP_TABWR);
  // Second word runs only after its move; reached alone it does nothing
  wire        dec_mvdst = exec_valid_reg & copy_pend_reg &
                          (ins[15:12] == `QFP_OP_SECOND);                 // RL15
  // Adds aimed at the PC low byte become a computed jump
  wire        to_pc_low = acc & (lit == `QFP_PC_LOW_ADDR);
  wire        dec_cgoto = dec_addw & dest_f & to_pc_low;
  wire        dec_addf  = dec_addw & ~dec_cgoto;
  wire        dec_tlat  = dec_stow & acc & (lit == `QFP_TLATCH_ADDR);
  wire        dec_mvf   = dec_stow & ~dec_tlat;

  // Any instruction that rewrites the PC
  wire        transfer  = dec_goto | dec_call | dec_rjmp | dec_rtlit | dec_cgoto;

  // ----------------------------------------------------------------------
  // Branch target arithmetic; fetch_addr_reg already points past the branch
  // ----------------------------------------------------------------------
  // Word offset doubled and sign-extended to byte distance
  wire [`QFP_PC_W-1:0] rel_off  = {{(`QFP_PC_W-12){ins[10]}}, ins[10:0], 1'b0};  // RL11
  wire [`QFP_PC_W-1:0] rel_tgt  = fetch_addr_reg + rel_off;                       // RL11
  // Second word supplies the upper bits of the word address
  wire [`QFP_PC_W-1:0] abs_tgt  = {pm_data_i[11:0], lit, 1'b0};                   // RL10
  // Working register added to low byte, LSB held at zero
  wire [7:0]           pc_low_sum = fetch_addr_reg[7:0] + working_register_reg;   // RL12
  wire [`QFP_PC_W-1:0] cg_tgt   = {fetch_addr_reg[`QFP_PC_W-1:8], pc_low_sum[7:1], 1'b0}; // RL12 RL9

  reg  [`QFP_PC_W-1:0] target;

  // Pick the transfer target
  always @*
  begin
    if (dec_rjmp)
    begin
      target = rel_tgt;
    end
    else if (dec_rtlit)
    begin
      target = ret_addr_reg;                                              // RL13
    end
    else if (dec_cgoto)
    begin
      target = cg_tgt;
    end
    else
    begin
      target = abs_tgt;                                                   // RL10
    end
  end

  // Access bank mapping of an 8-bit file address
  wire [`QFP_DM_AW-1:0] acc_addr = (lit < `QFP_ACC_SPLIT) ? {`QFP_BANK_LO, lit}
                                                          : {`QFP_BANK_HI, lit};

  // ----------------------------------------------------------------------
  // Phase generator
  // ----------------------------------------------------------------------
  // Four single-cycle phases repeating in order
  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      phase_reg <= `QFP_PH_Q1;                                            // RL16
    end
    else
    begin
      phase_reg <= phase_reg + 2'h1;                                      // RL1
    end
  end

  // ----------------------------------------------------------------------
  // Program counter and fetch address
  // ----------------------------------------------------------------------
  // PC advances in Q1; a transfer overwrites it in Q4
  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      pc_reg         <= `QFP_RESET_VEC;
      fetch_addr_reg <= `QFP_RESET_VEC;
      pm_addr_reg    <= `QFP_RESET_VEC;
      ret_addr_reg   <= `QFP_RESET_VEC;
    end
    else
    begin
      if (ph1)
      begin
        // Start of fetch cycle
        fetch_addr_reg <= pc_reg;                                         // RL2
        pc_reg         <= pc_reg + `QFP_PC_STEP;                          // RL2 RL9
        pm_addr_reg    <= dec_tabrd | dec_tabwr ? table_pointer_i : pc_reg; // RL14
      end
      else if (ph2)
      begin
        // Table slot over, point back at the fetch word
        pm_addr_reg <= fetch_addr_reg;                                    // RL8
      end
      else if (ph4 & transfer)
      begin
        pc_reg <= target;                                                 // RL7
        if (dec_call)
        begin
          // Return lands after the second word
          ret_addr_reg <= fetch_addr_reg + `QFP_PC_STEP;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Instruction latch and flush
  // ----------------------------------------------------------------------
  // Next word captured in Q4 while the current one finishes
  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      instruction_latch_reg <= {`QFP_WORD_W{1'b0}};
      exec_valid_reg        <= 1'b0;                                      // RL16
      copy_pend_reg         <= 1'b0;
    end
    else if (ph4)
    begin
      instruction_latch_reg <= pm_data_i;                                 // RL3 RL6
      // A transfer turns the prefetched word into a no-op
      exec_valid_reg        <= ~transfer;                                 // RL7
      copy_pend_reg         <= dec_fcopy;
    end
  end

  // ----------------------------------------------------------------------
  // Data path: address in Q1, read in Q2, result in Q3, write in Q4
  // ----------------------------------------------------------------------
  // Operand and destination address for the executing word
  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      dm_addr_reg <= {`QFP_DM_AW{1'b0}};
      operand_reg <= {`QFP_BYTE_W{1'b0}};
      result_reg  <= {`QFP_BYTE_W{1'b0}};
    end
    else
    begin
      if (ph1)
      begin
        // Source for a move, destination for its second word
        if (dec_fcopy | dec_mvdst)
        begin
          dm_addr_reg <= ins[`QFP_DM_AW-1:0];
        end
        else
        begin
          dm_addr_reg <= acc_addr;                                        // RL4
        end
      end
      if (ph2 & (dec_addf | dec_fcopy))
      begin
        operand_reg <= dm_rdata_i;                                        // RL5
      end
      if (ph3)
      begin
        if (dec_addf)
        begin
          result_reg <= operand_reg + working_register_reg;
        end
        else if (dec_mvf)
        begin
          result_reg <= working_register_reg;
        end
        else if (dec_mvdst)
        begin
          // Moved byte held since the first word
          result_reg <= operand_reg;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Working register and table latch
  // ----------------------------------------------------------------------
  // Register results land at the end of Q4; a table read loads the table latch at the end of Q2
  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      working_register_reg <= `QFP_WORK_RST;
      table_data_latch_reg <= {`QFP_BYTE_W{1'b0}};
    end
    else
    begin
      if (ph4)
      begin
        if (dec_ldlit | dec_rtlit)
        begin
          working_register_reg <= lit;                                    // RL13
        end
        else if (dec_addf & ~dest_f)
        begin
          working_register_reg <= result_reg;
        end
        if (dec_tlat)
        begin
          table_data_latch_reg <= working_register_reg;
        end
      end
      if (ph2 & dec_tabrd)
      begin
        // One byte, chosen by the pointer's low bit
        table_data_latch_reg <= table_pointer_i[0] ? pm_data_i[15:8]
                                                   : pm_data_i[7:0];      // RL14
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign q1_o               = ph1;                                        // RL1
  assign q2_o               = ph2;
  assign q3_o               = ph3;
  assign q4_o               = ph4;
  assign pm_addr_o          = pm_addr_reg;
  // Fetch read in Q4, table read in Q2
  assign pm_rd_o            = ph4 | (ph2 & dec_tabrd);                    // RL3
  assign pm_wr_o            = ph2 & dec_tabwr;                            // RL14
  assign pm_wdata_o         = table_data_latch_reg;
  assign dm_addr_o          = dm_addr_reg;
  assign dm_rd_o            = ph2 & (dec_addf | dec_fcopy);               // RL5
  assign dm_wr_o            = ph4 & ((dec_addf & dest_f) | dec_mvf | dec_mvdst); // RL5
  assign dm_wdata_o         = result_reg;
  assign table_data_latch_o = table_data_latch_reg;
  assign pc_o               = pc_reg;                                     // RL9
  assign working_register_o = working_register_reg;
  assign exec_valid_o       = exec_valid_reg;

endmodule

`default_nettype wire

// ==== qfp_map.vh ====
// Constants for the quad-phase fetch pipeline: widths, phases, opcode patterns
`ifndef QFP_MAP_VH
`define QFP_MAP_VH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define QFP_PC_W          21
`define QFP_WORD_W        16
`define QFP_DM_AW         12
`define QFP_BYTE_W        8

// ----------------------------------------------------------------------
// Phase codes and reset values
// ----------------------------------------------------------------------
`define QFP_PH_Q1         2'h0
`define QFP_PH_Q2         2'h1
`define QFP_PH_Q3         2'h2
`define QFP_PH_Q4         2'h3
`define QFP_RESET_VEC     21'h000000
`define QFP_PC_STEP       21'h000002
`define QFP_WORK_RST      8'h00

// ----------------------------------------------------------------------
// Special data addresses inside the access bank
// ----------------------------------------------------------------------
`define QFP_PC_LOW_ADDR   8'hF9
`define QFP_TLATCH_ADDR   8'hF5
`define QFP_ACC_SPLIT     8'h80
`define QFP_BANK_LO       4'h0
`define QFP_BANK_HI       4'hF

// ----------------------------------------------------------------------
// Opcode prefixes, compared against the top bits of the word; the two table opcodes match the whole word
// ----------------------------------------------------------------------
`define QFP_OP_GOTO       8'hEF
`define QFP_OP_CALL       7'h76
`define QFP_OP_RJMP       5'h1A
`define QFP_OP_FCOPY      4'hC
`define QFP_OP_SECOND     4'hF
`define QFP_OP_ADDW       6'h09
`define QFP_OP_STOW       7'h37
`define QFP_OP_LDLIT      8'h0E
`define QFP_OP_RTLIT      8'h0C
`define QFP_OP_TABRD      16'h0008
`define QFP_OP_TABWR      16'h000C

`endif

// ==== qfp_mem_model.sv ====
// Program and data memory arrays facing the fetch pipeline
`timescale 1ns/100ps
`default_nettype none

module qfp_mem_model
(
  // Clock
  input  wire logic        sys_clk_i,
  // Program memory side
  input  wire logic [20:0] pm_addr_i,
  input  wire logic        pm_rd_i,
  output wire logic [15:0] pm_data_o,
  input  wire logic        pm_wr_i,
  input  wire logic [7:0]  pm_wdata_i,
  // Data memory side
  input  wire logic [11:0] dm_addr_i,
  input  wire logic        dm_rd_i,
  output wire logic [7:0]  dm_rdata_o,
  input  wire logic        dm_wr_i,
  input  wire logic [7:0]  dm_wdata_i
);
  logic [15:0] pmem [0:511];  // Word array, indexed by byte address bits 9:1
  logic [7:0]  dmem [0:4095]; // Byte array, full 12-bit address
  logic [20:0] tw_addr;       // Last table write address
  logic [7:0]  tw_data;       // Last table write byte

  // Reads answer at once; without a strobe the lines carry the inverse so stale data never matches
  assign pm_data_o  = pm_rd_i ? pmem[pm_addr_i[9:1]] : ~pmem[pm_addr_i[9:1]];
  assign dm_rdata_o = dm_rd_i ? dmem[dm_addr_i] : ~dmem[dm_addr_i];

  // Writes land at the edge that ends the strobe cycle
  always @(posedge sys_clk_i)
  begin
    if (dm_wr_i)
      dmem[dm_addr_i] <= dm_wdata_i;
    // Table write records one byte with its full byte address
    if (pm_wr_i)
    begin
      tw_addr <= pm_addr_i;
      tw_data <= pm_wdata_i;
    end
  end
endmodule

`default_nettype wire

// ==== qfp_fetch_pipeline_monitor.sv ====
// Port checker for the quad-phase fetch pipeline
`timescale 1ns/100ps
`default_nettype none
`include "qfp_map.vh"

module qfp_fetch_pipeline_monitor
(
  // Clock and reset
  input wire logic                     sys_clk_i,
  input wire logic                     sys_rst_i,
  // Phases
  input wire logic                     q1_o,
  input wire logic                     q2_o,
  input wire logic                     q3_o,
  input wire logic                     q4_o,
  // Program memory
  input wire logic [`QFP_PC_W-1:0]     pm_addr_o,
  input wire logic                     pm_rd_o,
  input wire logic [`QFP_WORD_W-1:0]   pm_data_i,
  input wire logic                     pm_wr_o,
  input wire logic [`QFP_BYTE_W-1:0]   pm_wdata_o,
  // Data memory
  input wire logic [`QFP_DM_AW-1:0]    dm_addr_o,
  input wire logic                     dm_rd_o,
  input wire logic [`QFP_BYTE_W-1:0]   dm_rdata_i,
  input wire logic                     dm_wr_o,
  input wire logic [`QFP_BYTE_W-1:0]   dm_wdata_o,
  // Table and status
  input wire logic [`QFP_PC_W-1:0]     table_pointer_i,
  input wire logic [`QFP_BYTE_W-1:0]   table_data_latch_o,
  input wire logic [`QFP_PC_W-1:0]     pc_o,
  input wire logic [`QFP_BYTE_W-1:0]   working_register_o,
  input wire logic                     exec_valid_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // ----------------------------------------------------------------------
  // Phase and strobe timing
  // ----------------------------------------------------------------------
  AST_PHASE_ONEHOT: assert property ($onehot({q1_o, q2_o, q3_o, q4_o}))
    else $error("phase indicators not one-hot");
  AST_PHASE_ORDER: assert property (q1_o |=> q2_o ##1 q3_o ##1 q4_o ##1 q1_o)
    else $error("phase order broken");
  AST_FETCH_Q4: assert property (q4_o |-> pm_rd_o && !pm_addr_o[0])
    else $error("no even fetch in fourth phase");
  AST_PM_RD_PHASE: assert property (pm_rd_o |-> q4_o || (q2_o && exec_valid_o))
    else $error("program read outside its phases");
  AST_DM_RD_Q2: assert property (dm_rd_o |-> q2_o && exec_valid_o)
    else $error("data read outside second phase");
  AST_DM_WR_Q4: assert property (dm_wr_o |-> q4_o && exec_valid_o)
    else $error("data write outside fourth phase or from flushed word");
  AST_PM_WR_Q2: assert property (pm_wr_o |-> q2_o && exec_valid_o)
    else $error("table write outside second phase");

  // ----------------------------------------------------------------------
  // Counter, address and reset
  // ----------------------------------------------------------------------
  AST_PC_EVEN: assert property (!pc_o[0])
    else $error("program counter odd");
  // A table access borrows the second phase; the pointer then drives the address
  AST_ADDR_FROM_PC: assert property (q1_o |=>
    pm_addr_o == ((pm_rd_o || pm_wr_o) ? $past(table_pointer_i) : $past(pc_o)))
    else $error("fetch address not taken from counter or table pointer");
  AST_ADDR_HOLD: assert property (q3_o |=> $stable(pm_addr_o))
    else $error("fetch address moved before capture");
  AST_RESET_STATE: assert property ($fell(sys_rst_i) |-> q1_o && pc_o == 0 && !exec_valid_o)
    else $error("state after reset wrong");
endmodule

`default_nettype wire

// ==== qfp_fetch_pipeline_bench.sv ====
// Self-checking bench for the quad-phase fetch pipeline
`timescale 1ns/100ps
`default_nettype none

module qfp_fetch_pipeline_bench;
  logic        sys_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [20:0] table_pointer_i = 21'h000000;
  logic        q1_o, q2_o, q3_o, q4_o, pm_rd_o, pm_wr_o, dm_rd_o, dm_wr_o, exec_valid_o;
  logic [20:0] pm_addr_o, pc_o;
  logic [15:0] pm_data_i;
  logic [11:0] dm_addr_o;
  logic [7:0]  pm_wdata_o, dm_rdata_i, dm_wdata_o, table_data_latch_o, working_register_o;
  int          fail_count = 0;
  int          num_checks = 0;

  always #5 sys_clk_i = ~sys_clk_i;

  qfp_fetch_pipeline qfp_fetch_pipeline_i (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .q1_o(q1_o), .q2_o(q2_o), .q3_o(q3_o), .q4_o(q4_o), .pm_addr_o(pm_addr_o), .pm_rd_o(pm_rd_o),
    .pm_data_i(pm_data_i), .pm_wr_o(pm_wr_o), .pm_wdata_o(pm_wdata_o), .dm_addr_o(dm_addr_o),
    .dm_rd_o(dm_rd_o), .dm_rdata_i(dm_rdata_i), .dm_wr_o(dm_wr_o), .dm_wdata_o(dm_wdata_o),
    .table_pointer_i(table_pointer_i), .table_data_latch_o(table_data_latch_o), .pc_o(pc_o),
    .working_register_o(working_register_o), .exec_valid_o(exec_valid_o));

  qfp_mem_model qfp_mem_model_i (.sys_clk_i(sys_clk_i), .pm_addr_i(pm_addr_o), .pm_rd_i(pm_rd_o),
    .pm_data_o(pm_data_i), .pm_wr_i(pm_wr_o), .pm_wdata_i(pm_wdata_o), .dm_addr_i(dm_addr_o),
    .dm_rd_i(dm_rd_o), .dm_rdata_o(dm_rdata_i), .dm_wr_i(dm_wr_o), .dm_wdata_i(dm_wdata_o));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task run(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask

  // Holds reset and wipes both arrays; empty program words run as no-ops
  task clear;
    sys_rst_i = 1'b1;
    for (int i = 0; i < 4096; i++)
    begin
      qfp_mem_model_i.dmem[i] = 8'h00;
      if (i < 512)
        qfp_mem_model_i.pmem[i] = 16'hFFFF;
    end
  endtask

  // Loads eight words from a byte address
  task prog(input int base, input logic [15:0] w [8]);
    for (int i = 0; i < 8; i++)
      qfp_mem_model_i.pmem[base / 2 + i] = w[i];
  endtask

  // Six cycles of reset, then release
  task start;
    run(6);
    check("q1 in reset", q1_o, 1);
    check("pc in reset", pc_o, 0);
    check("flushed in reset", exec_valid_o, 0);
    sys_rst_i = 1'b0;
  endtask

  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Literal load, add into file, file-to-file copy, add into W, back to back
  task t_seq;
    clear;
    qfp_mem_model_i.dmem[16] = 8'h21;
    prog(0, '{16'h0E55, 16'h2610, 16'hC010, 16'hF011, 16'h2411, 16'hD7FF, 16'hFFFF, 16'hFFFF});
    start;
    run(14);
    check("add result early", qfp_mem_model_i.dmem[16], 8'h76);
    check("copy not yet", qfp_mem_model_i.dmem[17], 8'h00);
    run(50);
    check("copy result", qfp_mem_model_i.dmem[17], 8'h76);
    check("w after seq", working_register_o, 8'hCB);
  endtask

  // Absolute jump over two words onto a lone second word
  task t_goto;
    clear;
    qfp_mem_model_i.dmem[12'h123] = 8'h5A;
    prog(0, '{16'h0E66, 16'hEF05, 16'hF000, 16'h0E11, 16'h0E22, 16'hF123, 16'h6E20, 16'hD7FF});
    start;
    run(64);
    check("w after jump", working_register_o, 8'h66);
    check("store after jump", qfp_mem_model_i.dmem[32], 8'h66);
    check("pc bit0", pc_o[0], 0);
    check("lone second word", qfp_mem_model_i.dmem[12'h123], 8'h5A);
  endtask

  // Forward relative jump, then a self loop that must never fall through
  task t_branch;
    clear;
    prog(0, '{16'h0E77, 16'hD002, 16'h0E11, 16'h0E44, 16'h6E30, 16'hD7FF, 16'h6E31, 16'hFFFF});
    start;
    run(64);
    check("w after branch", working_register_o, 8'h77);
    check("branch target store", qfp_mem_model_i.dmem[48], 8'h77);
    check("loop tail unused", qfp_mem_model_i.dmem[49], 8'h00);
  endtask

  // Call into a table, add offset to counter low byte, return a literal
  task t_cgoto;
    clear;
    prog(0, '{16'h0E04, 16'hEC80, 16'hF000, 16'h6E40, 16'hD7FF, 16'hFFFF, 16'hFFFF, 16'hFFFF});
    prog(256, '{16'h26F9, 16'h0C11, 16'h0C22, 16'h0C33, 16'h0C44, 16'hFFFF, 16'hFFFF, 16'hFFFF});
    start;
    run(80);
    check("table literal", working_register_o, 8'h33);
    check("stored literal", qfp_mem_model_i.dmem[64], 8'h33);
  endtask

  // Byte write then byte read of program memory at an odd pointer
  task t_table;
    clear;
    table_pointer_i = 21'h000201;
    prog(0, '{16'h0E5A, 16'h6EF5, 16'h000C, 16'h0008, 16'hD7FF, 16'hFFFF, 16'hFFFF, 16'hFFFF});
    prog(512, '{16'hABCD, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF});
    start;
    run(64);
    check("write address", qfp_mem_model_i.tw_addr, 21'h000201);
    check("write byte", qfp_mem_model_i.tw_data, 8'h5A);
    check("read high byte", table_data_latch_o, 8'hAB);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial
  begin
    t_seq;
    t_goto;
    t_branch;
    t_cgoto;
    t_table;
    report_and_stop;
  end

  initial
  begin
    #20000;
    fail_count++;
    report_and_stop;
  end
endmodule

bind qfp_fetch_pipeline qfp_fetch_pipeline_monitor qfp_fetch_pipeline_monitor_i (.sys_clk_i(sys_clk_i),
  .sys_rst_i(sys_rst_i), .q1_o(q1_o), .q2_o(q2_o), .q3_o(q3_o), .q4_o(q4_o), .pm_addr_o(pm_addr_o),
  .pm_rd_o(pm_rd_o), .pm_data_i(pm_data_i), .pm_wr_o(pm_wr_o), .pm_wdata_o(pm_wdata_o),
  .dm_addr_o(dm_addr_o), .dm_rd_o(dm_rd_o), .dm_rdata_i(dm_rdata_i), .dm_wr_o(dm_wr_o),
  .dm_wdata_o(dm_wdata_o), .table_pointer_i(table_pointer_i), .table_data_latch_o(table_data_latch_o),
  .pc_o(pc_o), .working_register_o(working_register_o), .exec_valid_o(exec_valid_o));

`default_nettype wire
